//--- vlp_gas_train.sv
// Gas train model: space between valves and its pressure switch
module vlp_gas_train (
   input  wire logic clk_sys,         // Clock
   input  wire logic reset_n,         // Reset, active low
   input  wire logic upstreamValve,   // Upstream drive
   input  wire logic downstreamValve, // Downstream drive
   input  wire logic leakUp,          // Upstream seat leaks
   input  wire logic leakDown,        // Downstream seat leaks
   output logic      pressureSwitch   // High = space pressurised
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open valve sets the pressure; a leaky closed seat drifts it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) pressureSwitch <= 1'h0;
      else if (upstreamValve || (leakUp && !downstreamValve)) pressureSwitch <= 1'h1;
      else if (downstreamValve || leakDown) pressureSwitch <= 1'h0;
   end
endmodule

//--- vlp_params.svh
// Constants for the valve proving sequencer: encodings, timings, setup limits
`ifndef VLP_PARAMS_SVH
`define VLP_PARAMS_SVH

// System clock rate in hertz
`define VLP_CLK_HZ          250000000
// Interval figures in seconds
`define VLP_VALVE_PULSE_S   4
`define VLP_SETTLE_S        3
`define VLP_COMMIT_HOLD_S   5
// Cycles per one-second tick and cycles for the commit hold
`define VLP_TICK_CYCLES     (`VLP_CLK_HZ)
`define VLP_HOLD_CYCLES     (`VLP_COMMIT_HOLD_S * `VLP_CLK_HZ)

// Test time steps and limits, in seconds
`define VLP_FINE_MAX_S      12'h03C
`define VLP_MID_MAX_S       12'h258
`define VLP_COARSE_MAX_S    12'hE10
`define VLP_MID_STEP_S      12'h00A
`define VLP_COARSE_STEP_S   12'h03C

// Setup password digits
`define VLP_PW_FIRST        4'h7
`define VLP_PW_SECOND       4'h8

// Reset values of the committed settings
`define VLP_RST_SCHEDULE    3'h0
`define VLP_RST_TEST_TIME   12'h000

// Lockout cause codes
`define VLP_CAUSE_NONE      2'h0
`define VLP_CAUSE_BOTH_DMD  2'h1
`define VLP_CAUSE_NEVER_DMD 2'h2
`define VLP_CAUSE_TEST_FAIL 2'h3

// Bit positions in the synchronised pin vector
`define VLP_PIN_PSW         0
`define VLP_PIN_DMD         1
`define VLP_PIN_PDMD        2
`define VLP_PIN_BTN         3

`endif

//--- vlp_pkg.sv
// Types shared by the valve proving sequencer
package vlp_pkg;

   typedef enum logic [2:0] {
      SCHED_NEVER  = 3'b000,
      SCHED_BEFORE = 3'b001,
      SCHED_AFTER  = 3'b010,
      SCHED_BOTH   = 3'b011,
      SCHED_SPLIT  = 3'b100
   } vlp_sched_t;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_DEPRESS   = 3'b001,
      ST_SETTLE_LO = 3'b010,
      ST_MON_LO    = 3'b011,
      ST_PRESS     = 3'b100,
      ST_SETTLE_HI = 3'b101,
      ST_MON_HI    = 3'b110,
      ST_LOCK      = 3'b111
   } vlp_state_t;

   typedef struct packed {
      vlp_state_t  st;
      logic [3:0]  syncA;
      logic [3:0]  syncB;
      logic [3:0]  syncC;
      logic [3:0]  pinFlt;
      logic [31:0] tickCnt;
      logic [11:0] secCnt;
      logic [31:0] holdCnt;
      logic        holdSpent;
      logic        runHigh;
      vlp_sched_t  sched;
      logic [11:0] testTime;
      vlp_sched_t  pendSched;
      logic [11:0] pendTime;
      logic        pendValid;
      logic        upValve;
      logic        downValve;
      logic        done;
      logic [1:0]  cause;
      logic        ack;
      logic        nak;
      logic        commit;
   } vlp_regs_t;

endpackage

//--- vlp_props.sv
// Port checker for the valve proving sequencer
`include "vlp_params.svh"
module vlp_props
   import vlp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10,
   parameter int unsigned HOLD_CYCLES = 50
) (
   input wire logic        clk_sys,         // Clock
   input wire logic        reset_n,         // Reset, active low
   input wire logic        demandNormal,    // Ordinary demand
   input wire logic        demandProving,   // Proving demand
   input wire logic        burnerStandby,   // Standby level
   input wire logic        setupReq,        // Setup request
   input wire logic [3:0]  pwDigitFirst,    // First digit
   input wire logic [3:0]  pwDigitSecond,   // Second digit
   input wire logic        upstreamValve,   // Upstream drive
   input wire logic        downstreamValve, // Downstream drive
   input wire logic        lockout,         // Lockout level
   input wire logic [1:0]  lockoutCause,    // Lockout reason
   input wire logic        setupReject,     // Setup refused
   input wire logic [2:0]  activeSchedule   // Committed schedule
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PULSE = `VLP_VALVE_PULSE_S * TICK_CYCLES;
   logic [31:0] dnRun, upRun;
   // Pulse lengths run to a billion cycles at 250 MHz, so count them here
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dnRun <= 32'h0;
         upRun <= 32'h0;
      end else begin
         dnRun <= downstreamValve ? dnRun + 32'h1 : 32'h0;
         upRun <= upstreamValve ? upRun + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_quiet; (lockoutCause != `VLP_CAUSE_TEST_FAIL)[*8]; endsequence
   sequence s_dual; lockout && lockoutCause == `VLP_CAUSE_BOTH_DMD; endsequence
   sequence s_never; lockout && lockoutCause == `VLP_CAUSE_NEVER_DMD; endsequence
   a_lock_valves_off: assert property (lockout |-> !upstreamValve && !downstreamValve)
      else $error("valve open in lockout");
   a_valves_excl: assert property (!(upstreamValve && downstreamValve))
      else $error("both valves open");
   a_dn_pulse_len: assert property ($fell(downstreamValve) && !lockout |-> dnRun == PULSE)
      else $error("downstream pulse length wrong");
   a_up_pulse_len: assert property ($fell(upstreamValve) && !lockout |-> upRun == PULSE)
      else $error("upstream pulse length wrong");
   a_settle_quiet: assert property ($fell(downstreamValve) && !lockout |=> s_quiet)
      else $error("test fail during settle");
   a_setup_refuse: assert property (setupReq && !burnerStandby && !lockout |-> ##[1:2] setupReject)
      else $error("setup taken outside standby");
   a_pw_check: assert property (setupReq && (pwDigitFirst != `VLP_PW_FIRST ||
      pwDigitSecond != `VLP_PW_SECOND) |-> ##[1:2] setupReject)
      else $error("wrong password accepted");
   a_both_dmd: assert property ($rose(demandNormal && demandProving) && !lockout |-> ##[3:8] s_dual)
      else $error("no lockout on both demands");
   // proving demand under Never locks out
   a_never_dmd: assert property ($rose(demandProving) && !demandNormal && !lockout &&
      activeSchedule == 3'h0 |-> ##[3:8] s_never)
      else $error("no lockout on demand with Never");
endmodule
bind vlp_valve_proving_sequencer vlp_props #(.TICK_CYCLES(TICK_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_props (
   .clk_sys, .reset_n, .demandNormal, .demandProving, .burnerStandby, .setupReq, .pwDigitFirst,
   .pwDigitSecond, .upstreamValve, .downstreamValve, .lockout, .lockoutCause, .setupReject, .activeSchedule);

//--- vlp_valve_proving_sequencer.sv
// Valve seat proving sequencer: schedule, pulses, settle, monitoring, setup and lockout
//
// Contract
// - Five schedules, default Never runs nothing.
// - Before runs full test with prepurge.
// - After runs test after Run phase.
// - Both runs full test at both times.
// - Split: high test before, low after.
// - Proving runs only with proving demand.
// - Test time steps 1s, 10s, 1min.
// - All intervals within ten percent nominal.
// - Downstream valve pulse four seconds first.
// - Ignore switch three seconds after pulse.
// - Switch active in low test locks out.
// - Upstream valve pulse four seconds second.
// - Switch inactive in high test locks.
// - Low check precedes high check in a full test.
// - Setup only in Standby or Lockout.
// - Setup needs password seven then eight.
// - Proving demand with Never locks out.
// - Both demands together lock out.
// - Settings commit after five second hold.
`include "vlp_params.svh"

module vlp_valve_proving_sequencer
   import vlp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `VLP_TICK_CYCLES,
   parameter int unsigned HOLD_CYCLES = `VLP_HOLD_CYCLES
) (
   input  wire logic        clk_sys,         // System clock, 250 MHz
   input  wire logic        reset_n,         // Asynchronous reset, active low
   input  wire logic        pressureSwitch,  // Proving pressure switch pin, high = pressure present
   input  wire logic        demandNormal,    // Ordinary demand pin
   input  wire logic        demandProving,   // Proving demand pin
   input  wire logic        resetButton,     // Reset button pin, high = pressed
   input  wire logic        burnerStandby,   // Burner sequence sits in Standby
   input  wire logic        beforeStart,     // Pulse: prepurge begins
   input  wire logic        afterStart,      // Pulse: Run ended, postpurge window opens
   input  wire logic        setupReq,        // Pulse: keypad submits a setup
   input  wire logic [3:0]  pwDigitFirst,    // Password first digit
   input  wire logic [3:0]  pwDigitSecond,   // Password second digit
   input  wire logic [2:0]  setupSchedule,   // Requested schedule
   input  wire logic [11:0] setupTestTime,   // Requested test time, seconds
   output logic             upstreamValve,   // Upstream valve drive
   output logic             downstreamValve, // Downstream valve drive
   output logic             provingBusy,     // A proving test is running
   output logic             provingDone,     // Pulse: test passed
   output logic             lockout,         // Lockout held
   output logic [1:0]       lockoutCause,    // Reason of the lockout
   output logic             setupAck,        // Pulse: setup staged
   output logic             setupReject,     // Pulse: setup refused
   output logic             commitDone,      // Pulse: staged setup committed
   output logic [2:0]       activeSchedule,  // Committed schedule
   output logic [11:0]      activeTestTime   // Committed test time, seconds
);

   // legal steps for the test time
   function automatic logic timeIsLegal(input logic [11:0] t);
      logic ok;
      ok = 1'b0;
      if (t <= `VLP_FINE_MAX_S) begin
         ok = 1'b1;
      end else if (t <= `VLP_MID_MAX_S) begin
         ok = ((t % `VLP_MID_STEP_S) == 12'h000);
      end else if (t <= `VLP_COARSE_MAX_S) begin
         ok = ((t % `VLP_COARSE_STEP_S) == 12'h000);
      end
      return ok;
   endfunction

   vlp_regs_t r_ff;
   vlp_regs_t nxt_r;

   logic        pswOn;
   logic        dmdOn;
   logic        pdmdOn;
   logic        btnOn;
   logic        secStep;
   logic        setupOpen;
   logic        setupGood;
   logic        schedLegal;
   logic [11:0] secNext;

   // Filtered pin levels
   assign pswOn  = r_ff.pinFlt[`VLP_PIN_PSW];
   assign dmdOn  = r_ff.pinFlt[`VLP_PIN_DMD];
   assign pdmdOn = r_ff.pinFlt[`VLP_PIN_PDMD];
   assign btnOn  = r_ff.pinFlt[`VLP_PIN_BTN];

   // One-second tick restarts with every step, so a short delay never loses a partial second
   // exact timing
   assign secStep = (r_ff.tickCnt == 32'(TICK_CYCLES - 1));
   assign secNext = secStep ? (r_ff.secCnt + 12'h001) : r_ff.secCnt;

   assign setupOpen  = (r_ff.st == ST_IDLE && burnerStandby) || (r_ff.st == ST_LOCK);
   assign schedLegal = (setupSchedule <= 3'(SCHED_SPLIT));
   assign setupGood  = setupOpen && (pwDigitFirst == `VLP_PW_FIRST) && (pwDigitSecond == `VLP_PW_SECOND)
                       && schedLegal && timeIsLegal(setupTestTime);

   // Next-state logic for the whole block
   always_comb begin
      nxt_r = r_ff;
      nxt_r.done   = 1'b0;
      nxt_r.ack    = 1'b0;
      nxt_r.nak    = 1'b0;
      nxt_r.commit = 1'b0;

      // three-stage pin synchronisers; level moves only when stages two and three agree
      nxt_r.syncA = {resetButton, demandProving, demandNormal, pressureSwitch};
      nxt_r.syncB = r_ff.syncA;
      nxt_r.syncC = r_ff.syncB;
      for (int i = 0; i < 4; i++) begin
         if (r_ff.syncB[i] == r_ff.syncC[i]) begin
            nxt_r.pinFlt[i] = r_ff.syncC[i];
         end
      end

      // Interval counters
      nxt_r.tickCnt = secStep ? 32'h0000_0000 : (r_ff.tickCnt + 32'h0000_0001);
      nxt_r.secCnt  = secNext;

      case (r_ff.st)
         ST_IDLE: begin
            nxt_r.tickCnt = 32'h0000_0000;
            nxt_r.secCnt  = 12'h000;
            if (pdmdOn && beforeStart) begin
               case (r_ff.sched)
                  SCHED_BEFORE, SCHED_BOTH: begin
                     nxt_r.st      = ST_DEPRESS;
                     nxt_r.runHigh = 1'b1;
                  end
                  // only the high pressure test here
                  SCHED_SPLIT: begin
                     nxt_r.st      = ST_PRESS;
                     nxt_r.runHigh = 1'b1;
                  end
                  // Never and After do nothing now
                  default: begin
                     nxt_r.st = ST_IDLE;
                  end
               endcase
            end else if (pdmdOn && afterStart) begin
               case (r_ff.sched)
                  SCHED_AFTER, SCHED_BOTH: begin
                     nxt_r.st      = ST_DEPRESS;
                     nxt_r.runHigh = 1'b1;
                  end
                  // only the low pressure test here
                  SCHED_SPLIT: begin
                     nxt_r.st      = ST_DEPRESS;
                     nxt_r.runHigh = 1'b0;
                  end
                  default: begin
                     nxt_r.st = ST_IDLE;
                  end
               endcase
            end
         end
         ST_DEPRESS: begin
            if (secNext == 12'(`VLP_VALVE_PULSE_S)) begin
               nxt_r.st = ST_SETTLE_LO;
            end
         end
         ST_SETTLE_LO: begin
            if (secNext == 12'(`VLP_SETTLE_S)) begin
               nxt_r.st = ST_MON_LO;
            end
         end
         // pressure rising means a leaky upstream seat
         ST_MON_LO: begin
            if (pswOn) begin
               nxt_r.st    = ST_LOCK;
               nxt_r.cause = `VLP_CAUSE_TEST_FAIL;
            end else if (secNext >= r_ff.testTime) begin
               // low check done; high check follows when runHigh is set, otherwise the test ends here
               nxt_r.st = r_ff.runHigh ? ST_PRESS : ST_IDLE;
               nxt_r.done = !r_ff.runHigh;
            end
         end
         ST_PRESS: begin
            if (secNext == 12'(`VLP_VALVE_PULSE_S)) begin
               nxt_r.st = ST_SETTLE_HI;
            end
         end
         ST_SETTLE_HI: begin
            if (secNext == 12'(`VLP_SETTLE_S)) begin
               nxt_r.st = ST_MON_HI;
            end
         end
         // pressure falling means a leaky downstream seat
         ST_MON_HI: begin
            if (!pswOn) begin
               nxt_r.st    = ST_LOCK;
               nxt_r.cause = `VLP_CAUSE_TEST_FAIL;
            end else if (secNext >= r_ff.testTime) begin
               nxt_r.st   = ST_IDLE;
               nxt_r.done = 1'b1;
            end
         end
         // held until the reset button is released
         ST_LOCK: begin
            nxt_r.tickCnt = 32'h0000_0000;
            nxt_r.secCnt  = 12'h000;
            if (r_ff.pinFlt[`VLP_PIN_BTN] && !nxt_r.pinFlt[`VLP_PIN_BTN]) begin
               nxt_r.st    = ST_IDLE;
               nxt_r.cause = `VLP_CAUSE_NONE;
            end
         end
         default: begin
            nxt_r.st = ST_LOCK;
         end
      endcase

      // Step changes restart the interval counters
      if (nxt_r.st != r_ff.st) begin
         nxt_r.tickCnt = 32'h0000_0000;
         nxt_r.secCnt  = 12'h000;
      end

      // Demand faults override the next step and cause outside lockout
      if (r_ff.st != ST_LOCK) begin
         if (dmdOn && pdmdOn) begin
            nxt_r.st    = ST_LOCK;
            nxt_r.cause = `VLP_CAUSE_BOTH_DMD;
         // proving demand while set to Never
         end else if (pdmdOn && r_ff.sched == SCHED_NEVER) begin
            nxt_r.st    = ST_LOCK;
            nxt_r.cause = `VLP_CAUSE_NEVER_DMD;
         end
      end

      // stage a new setup; it is not used until committed
      if (setupReq) begin
         if (setupGood) begin
            nxt_r.pendSched = vlp_sched_t'(setupSchedule);
            nxt_r.pendTime  = setupTestTime;
            nxt_r.pendValid = 1'b1;
            nxt_r.ack       = 1'b1;
         end else begin
            nxt_r.nak = 1'b1;
         end
      end

      // commit after the button is held five seconds, once per press
      if (!btnOn) begin
         nxt_r.holdCnt   = 32'h0000_0000;
         nxt_r.holdSpent = 1'b0;
      end else if (!r_ff.holdSpent) begin
         if (r_ff.holdCnt == 32'(HOLD_CYCLES - 1)) begin
            nxt_r.holdSpent = 1'b1;
            if (r_ff.pendValid && setupOpen) begin
               nxt_r.sched     = r_ff.pendSched;
               nxt_r.testTime  = r_ff.pendTime;
               // A setup staged in this same cycle survives for the next press
               nxt_r.pendValid = nxt_r.ack;
               nxt_r.commit    = 1'b1;
            end
         end else begin
            nxt_r.holdCnt = r_ff.holdCnt + 32'h0000_0001;
         end
      end

      // valves follow the step; lockout drives both off at once
      nxt_r.downValve = (nxt_r.st == ST_DEPRESS);
      nxt_r.upValve   = (nxt_r.st == ST_PRESS);
   end

   // State register; committed schedule resets to Never
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r_ff           <= '0;
         r_ff.st        <= ST_IDLE;
         r_ff.sched     <= vlp_sched_t'(`VLP_RST_SCHEDULE);
         r_ff.pendSched <= vlp_sched_t'(`VLP_RST_SCHEDULE);
         r_ff.testTime  <= `VLP_RST_TEST_TIME;
         r_ff.cause     <= `VLP_CAUSE_NONE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs, all from flip-flops except busy and lockout which decode the state register
   assign upstreamValve   = r_ff.upValve;
   assign downstreamValve = r_ff.downValve;
   assign provingBusy     = (r_ff.st != ST_IDLE) && (r_ff.st != ST_LOCK);
   assign provingDone     = r_ff.done;
   assign lockout         = (r_ff.st == ST_LOCK);
   assign lockoutCause    = r_ff.cause;
   assign setupAck        = r_ff.ack;
   assign setupReject     = r_ff.nak;
   assign commitDone      = r_ff.commit;
   assign activeSchedule  = r_ff.sched;
   assign activeTestTime  = r_ff.testTime;

endmodule

//--- vlp_valve_proving_sequencer_tb.sv
// Self-checking bench for the valve proving sequencer
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module vlp_valve_proving_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 10;
   localparam int HOLD = 50;
   logic        clk_sys = 1'h0, reset_n = 1'h0, demandNormal = 1'h0, demandProving = 1'h0;
   logic        resetButton = 1'h0, burnerStandby = 1'h1, beforeStart = 1'h0, afterStart = 1'h0;
   logic        setupReq = 1'h0, leakUp = 1'h0, leakDown = 1'h0;
   logic [3:0]  pwDigitFirst = 4'h0, pwDigitSecond = 4'h0;
   logic [2:0]  setupSchedule = 3'h0, activeSchedule;
   logic [11:0] setupTestTime = 12'h000, activeTestTime;
   logic        pressureSwitch, upstreamValve, downstreamValve, provingBusy, provingDone;
   logic        lockout, setupAck, setupReject, commitDone, dnFirst, doneSeen;
   logic [1:0]  lockoutCause;
   int          failures = 0, num_checks = 0, dnN, upN, gapN;
   vlp_valve_proving_sequencer #(.TICK_CYCLES(T), .HOLD_CYCLES(HOLD)) dut_u (.clk_sys, .reset_n,
      .pressureSwitch, .demandNormal, .demandProving, .resetButton, .burnerStandby, .beforeStart,
      .afterStart, .setupReq, .pwDigitFirst, .pwDigitSecond, .setupSchedule, .setupTestTime, .upstreamValve,
      .downstreamValve, .provingBusy, .provingDone, .lockout, .lockoutCause, .setupAck, .setupReject,
      .commitDone, .activeSchedule, .activeTestTime);
   vlp_gas_train gas_u (.clk_sys, .reset_n, .upstreamValve, .downstreamValve, .leakUp, .leakDown,
      .pressureSwitch);
   // Free-running system clock
   always #2 clk_sys = ~clk_sys;
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic pulse(bit aft);
      @(posedge clk_sys);
      if (aft) afterStart <= 1'h1;
      else beforeStart <= 1'h1;
      @(posedge clk_sys);
      afterStart <= 1'h0;
      beforeStart <= 1'h0;
      #1;
   endtask
   // Submit a setup and collect the one-cycle answer
   task automatic setup(logic [3:0] a, logic [3:0] b, logic [2:0] s, logic [11:0] t, logic ok);
      logic ack, rej;
      ack = 1'h0;
      rej = 1'h0;
      @(posedge clk_sys);
      {pwDigitFirst, pwDigitSecond, setupSchedule, setupTestTime, setupReq} <= {a, b, s, t, 1'h1};
      @(posedge clk_sys);
      setupReq <= 1'h0;
      repeat (3) begin
         #1;
         ack |= setupAck;
         rej |= setupReject;
         @(posedge clk_sys);
      end
      #1;
      `CHK("setupAck", ok, ack)
      `CHK("setupReject", !ok, rej)
   endtask
   // Hold the button until the staged setup commits
   task automatic commit(logic [2:0] s, logic [11:0] t);
      int n;
      n = 0;
      @(posedge clk_sys);
      resetButton <= 1'h1;
      while (commitDone !== 1'h1 && n < HOLD + 40) begin
         tick(1);
         n++;
      end
      `CHK("commitDone", 1'h1, commitDone)
      `CHK("holdLong", 1'h1, n >= HOLD)
      @(posedge clk_sys);
      resetButton <= 1'h0;
      tick(10);
      `CHK("activeSchedule", s, activeSchedule)
      `CHK("activeTestTime", t, activeTestTime)
      `CHK("lockout", 1'h0, lockout)
   endtask
   // Start a test and record pulse lengths and ordering
   task automatic run_test(bit aft);
      dnN = 0;
      upN = 0;
      gapN = 0;
      dnFirst = 1'h0;
      doneSeen = 1'h0;
      pulse(aft);
      `CHK("busyOn", 1'h1, provingBusy)
      for (int n = 0; n < 3000 && !doneSeen && lockout !== 1'h1; n++) begin
         if (downstreamValve) dnFirst = dnFirst | (upN == 0);
         dnN += downstreamValve;
         upN += upstreamValve;
         if (!downstreamValve && !upstreamValve && dnN > 0 && upN == 0) gapN++;
         doneSeen = provingDone;
         tick(1);
      end
      `CHK("busyOff", 1'h0, provingBusy)
   endtask
   task automatic t_never;
      `CHK("schedReset", 3'h0, activeSchedule)
      `CHK("timeReset", 12'h000, activeTestTime)
      @(posedge clk_sys);
      demandProving <= 1'h1;
      tick(12);
      `CHK("neverLock", {1'h1, 2'h2}, {lockout, lockoutCause})
      `CHK("valvesOff", 2'h0, {upstreamValve, downstreamValve})
      setup(4'h7, 4'h9, 3'h1, 12'h002, 1'h0);
      setup(4'h8, 4'h7, 3'h1, 12'h002, 1'h0);
      setup(4'h7, 4'h8, 3'h5, 12'h002, 1'h0);
      setup(4'h7, 4'h8, 3'h1, 12'h03D, 1'h0);
      setup(4'h7, 4'h8, 3'h1, 12'h262, 1'h0);
      setup(4'h7, 4'h8, 3'h1, 12'h294, 1'h1);
      setup(4'h7, 4'h8, 3'h1, 12'h002, 1'h1);
      @(posedge clk_sys);
      demandProving <= 1'h0;
      commit(3'h1, 12'h002);
   endtask
   task automatic t_before;
      @(posedge clk_sys);
      demandProving <= 1'h1;
      tick(8);
      pulse(1'h1);
      tick(4);
      `CHK("afterIgnored", 1'h0, provingBusy)
      run_test(1'h0);
      `CHK("dnPulse", 4 * T, dnN)
      `CHK("upPulse", 4 * T, upN)
      `CHK("gap", 5 * T, gapN)
      `CHK("order", 2'h3, {dnFirst, doneSeen})
   endtask
   task automatic t_split;
      @(posedge clk_sys);
      burnerStandby <= 1'h0;
      setup(4'h7, 4'h8, 3'h4, 12'h000, 1'h0);
      @(posedge clk_sys);
      burnerStandby <= 1'h1;
      setup(4'h7, 4'h8, 3'h4, 12'h000, 1'h1);
      commit(3'h4, 12'h000);
      run_test(1'h0);
      `CHK("splitBefore", {32'h0, 32'h28, 1'h1}, {dnN, upN, doneSeen})
      run_test(1'h1);
      `CHK("splitAfter", {32'h28, 32'h0, 1'h1}, {dnN, upN, doneSeen})
   endtask
   // After schedule: prepurge start is ignored, end of Run runs the full test
   task automatic t_after;
      setup(4'h7, 4'h8, 3'h2, 12'h002, 1'h1);
      commit(3'h2, 12'h002);
      pulse(1'h0);
      tick(4);
      `CHK("beforeIgnored", 1'h0, provingBusy)
      run_test(1'h1);
      `CHK("afterFull", {32'h28, 32'h28, 1'h1}, {dnN, upN, doneSeen})
   endtask
   task automatic release_lock;
      @(posedge clk_sys);
      resetButton <= 1'h1;
      tick(8);
      @(posedge clk_sys);
      resetButton <= 1'h0;
      tick(10);
      `CHK("released", 3'h0, {lockout, lockoutCause})
   endtask
   task automatic t_both;
      setup(4'h7, 4'h8, 3'h3, 12'h002, 1'h1);
      commit(3'h3, 12'h002);
      run_test(1'h1);
      `CHK("bothAfter", {32'h28, 32'h28, 1'h1}, {dnN, upN, doneSeen})
      leakDown <= 1'h1;
      run_test(1'h0);
      `CHK("highFail", {32'h28, 1'h1, 2'h3}, {upN, lockout, lockoutCause})
      `CHK("highValves", 2'h0, {upstreamValve, downstreamValve})
      leakDown <= 1'h0;
      release_lock();
      leakUp <= 1'h1;
      run_test(1'h0);
      `CHK("lowFail", {32'h28, 32'h0, 3'h7}, {dnN, upN, lockout, lockoutCause})
      `CHK("settleHeld", 1'h1, gapN >= 3 * T && gapN <= 3 * T + 8)
      leakUp <= 1'h0;
      release_lock();
      @(posedge clk_sys);
      demandNormal <= 1'h1;
      tick(12);
      `CHK("dualLock", 3'h5, {lockout, lockoutCause})
      @(posedge clk_sys);
      demandNormal <= 1'h0;
      release_lock();
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence: reset, then scenarios in order
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'h1;
      tick(6);
      t_never();
      t_before();
      t_split();
      t_after();
      t_both();
      end_sim();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
endmodule
